// ### bench/bmct_tcb_tbl.sv
// Trigger control block table that sits beside the sequencer.
// Assumes the sequencer looks blocks up from its registered indices.
`timescale 1ns/1ps
`default_nettype none
module bmct_tcb_tbl (
  // Block index per sequence
  input wire logic [7:0] idx_i [2],
  // Block fields per sequence
  output logic [15:0] msk_o [2],
  output logic [15:0] lo_o [2],
  output logic [15:0] hi_o [2],
  output logic [7:0] set_o [2],
  output logic [7:0] clr_o [2],
  output logic [7:0] nxt_o [2],
  output logic [7:0] eom_o [2]
);
  logic [15:0] msk [256];
  logic [15:0] lo [256];
  logic [15:0] hi [256];
  logic [7:0] st [256];
  logic [7:0] cl [256];
  logic [7:0] nx [256];
  logic [7:0] eo [256];
  // ----------------------------------------
  // Table contents
  // ----------------------------------------
  // Narrow windows; upper byte masked off so noise there must not matter
  initial begin
    for (int k = 0; k < 256; k++) begin
      msk[k] = 16'h00ff;
      lo[k] = {8'h00, k[3:0], 4'h2};
      hi[k] = {8'h00, k[3:0], 4'h5};
      st[k] = 8'h01 << k[1:0];
      cl[k] = 8'h01 << (k[1:0] + 2'h2);
      nx[k] = (k == 3) ? 8'h00 : (k == 9) ? 8'h08 : 8'(k + 1);
      eo[k] = (k < 8) ? 8'h00 : 8'h08;
    end
  end
  // Lookup is combinational, like an external table memory
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      msk_o[s] = msk[idx_i[s]];
      lo_o[s] = lo[idx_i[s]];
      hi_o[s] = hi[idx_i[s]];
      set_o[s] = st[idx_i[s]];
      clr_o[s] = cl[idx_i[s]];
      nxt_o[s] = nx[idx_i[s]];
      eom_o[s] = eo[idx_i[s]];
    end
  end
endmodule : bmct_tcb_tbl
`default_nettype wire

// ### bench/bmct_top_tb.sv
// Self-checking bench for the capture trigger block.
// Assumes the block table model and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module bmct_top_tb;
  import bmct_pkg::*;
  logic clk_i, srst_i, ce_i, wr_i, rd_i, word_vld_i, eom_i, xfer_vld_i;
  logic capture_o, irq_o;
  logic [3:0] addr_i;
  logic [31:0] wdata_i, rdata_o, xfer_data_i, e;
  logic [15:0] word_i;
  logic [4:0] xfer_rt_i;
  logic [1:0] xfer_kind_i;
  logic [15:0] t_msk [2], t_lo [2], t_hi [2];
  logic [7:0] t_set [2], t_clr [2], t_nxt [2], t_eom [2], cur_idx [2];
  logic [7:0] pattern_o;
  // Reference model state
  int mismatches, checks_done, seed;
  logic [7:0] pat_m, idx_m [2];
  logic [1:0] cap_m, mode_m;
  logic [2:0] irq_m;
  logic [31:0] match_m;
  logic [31:0] filt_m [3][32];
  logic [31:0] q_m [$];

  bmct_top dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .word_vld_i(word_vld_i), .word_i(word_i), .eom_i(eom_i),
    .tbl_mask_i(t_msk), .tbl_lo_i(t_lo), .tbl_hi_i(t_hi), .tbl_set_i(t_set),
    .tbl_clr_i(t_clr), .tbl_next_i(t_nxt), .tbl_eom_i(t_eom),
    .cur_idx_o(cur_idx), .xfer_vld_i(xfer_vld_i), .xfer_rt_i(xfer_rt_i),
    .xfer_kind_i(xfer_kind_i), .xfer_data_i(xfer_data_i),
    .capture_o(capture_o), .pattern_o(pattern_o), .irq_o(irq_o));
  bmct_tcb_tbl tcb (.idx_i(cur_idx), .msk_o(t_msk), .lo_o(t_lo),
    .hi_o(t_hi), .set_o(t_set), .clr_o(t_clr), .nxt_o(t_nxt),
    .eom_o(t_eom));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string nm, input logic [3:0] a,
                        input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check(nm, rdata_o, exp);
  endtask : rd_chk

  task automatic init_mode(input bmct_mode_t m);
    mode_m = m;
    pat_m = 8'h00;
    cap_m = 2'd0;
    idx_m[0] = 8'h00;
    idx_m[1] = 8'h08;
    q_m.delete();
    foreach (filt_m[i, j]) filt_m[i][j] = FILT_RESET;
    wr_reg(ADDR_CTRL, {29'h0, m, 1'b1});
    wr_reg(ADDR_IRQ_STAT, 32'h7);
    irq_m = 3'h0;
    repeat (2) @(posedge clk_i);
    #1 check("pattern", pattern_o, pat_m);
    check("capture", capture_o, 1'b0);
    check("seq0_idx", cur_idx[0], idx_m[0]);
    check("seq1_idx", cur_idx[1], idx_m[1]);
    rd_chk("ctrl", ADDR_CTRL, {29'h0, m, 1'b0});
  endtask : init_mode

  // Model first, then drive; both sequences may hit on one word
  task automatic send_word(input logic [15:0] w, input logic eom);
    logic [7:0] k, sm, cm;
    sm = 8'h00;
    cm = 8'h00;
    for (int s = 0; s < 2; s++) begin
      k = idx_m[s];
      if (!eom && (w & tcb.msk[k]) >= tcb.lo[k]
          && (w & tcb.msk[k]) <= tcb.hi[k]) begin
        sm |= tcb.st[k];
        cm |= tcb.cl[k];
        idx_m[s] = tcb.nx[k];
      end else if (eom) begin
        idx_m[s] = tcb.eo[k];
      end
    end
    pat_m = (pat_m & ~cm) | sm;
    if (cap_m == 2'd0 && (pat_m & match_m[15:8]) == match_m[7:0]) begin
      cap_m = 2'd1;
      irq_m[IRQ_START] = 1'b1;
    end
    if (cap_m == 2'd1 && mode_m == MODE_STANDARD
        && (pat_m & match_m[31:24]) == match_m[23:16]) begin
      cap_m = 2'd2;
      irq_m[IRQ_STOP] = 1'b1;
    end
    @(posedge clk_i);
    word_vld_i <= !eom;
    eom_i <= eom;
    word_i <= w;
    @(posedge clk_i);
    word_vld_i <= 1'b0;
    eom_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1 check("pattern", pattern_o, pat_m);
    check("capture", capture_o, cap_m == 1);
    check("seq0_idx", cur_idx[0], idx_m[0]);
    check("seq1_idx", cur_idx[1], idx_m[1]);
  endtask : send_word

  // Words biased to the window edges of the current blocks
  task automatic step();
    logic [31:0] r;
    logic [7:0] k, low;
    r = $random(seed);
    k = idx_m[r[2]];
    case (r[1:0])
      2'd0: low = tcb.lo[k][7:0];
      2'd1: low = tcb.hi[k][7:0];
      2'd2: low = tcb.hi[k][7:0] + 8'h01;
      default: low = r[23:16];
    endcase
    send_word({r[15:8], low}, r[5:3] == 3'h0);
  endtask : step

  task automatic run_to(input logic [1:0] target);
    for (int n = 0; n < 300 && cap_m != target; n++) step();
  endtask : run_to

  task automatic send_xfer();
    logic [31:0] r, d;
    logic [4:0] rt;
    logic [1:0] kd;
    r = $random(seed);
    d = $random(seed);
    rt = r[0] ? 5'd5 : r[8:4];
    kd = (r[10:9] == 2'h3) ? KIND_TX : r[10:9];
    if (r[1]) d[4:0] = 5'h00;
    if (mode_m == MODE_QUEUING && cap_m == 2'd1
        && filt_m[kd][rt][d[4:0]]) begin
      if (q_m.size() < QDEPTH) q_m.push_back(d);
      else irq_m[IRQ_QOVF] = 1'b1;
    end
    @(posedge clk_i);
    xfer_vld_i <= 1'b1;
    xfer_rt_i <= rt;
    xfer_kind_i <= kd;
    xfer_data_i <= d;
    @(posedge clk_i);
    xfer_vld_i <= 1'b0;
    @(posedge clk_i);
  endtask : send_xfer

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Longest path is three phases of at most 300, 340 and 300 words
  initial begin
    repeat (30000) @(posedge clk_i);
    mismatches++;
    stop_test();
  end

  initial begin
    {wr_i, rd_i, word_vld_i, eom_i, xfer_vld_i} = 5'h00;
    {addr_i, wdata_i, word_i, xfer_rt_i, xfer_kind_i, xfer_data_i} = '0;
    ce_i = 1'b1;
    srst_i = 1'b1;
    seed = 57;
    mismatches = 0;
    checks_done = 0;
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    #1 check("pattern", pattern_o, 8'h00);
    match_m = 32'h0c04_0303;
    wr_reg(ADDR_MATCH, match_m);
    wr_reg(ADDR_INDEX, 32'hfedc_0800);
    wr_reg(4'hf, 32'h1234_5678);
    rd_chk("match", ADDR_MATCH, match_m);
    rd_chk("index", ADDR_INDEX, 32'h0000_0800);
    rd_chk("unmapped", 4'hf, 32'h0);
    // Standard mode runs from start to stop
    init_mode(MODE_STANDARD);
    run_to(2'd2);
    rd_chk("status", ADDR_STATUS, {16'h0, 6'h0, cap_m, pat_m});
    rd_chk("irq_stat", ADDR_IRQ_STAT, {29'h0, irq_m});
    wr_reg(ADDR_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clk_i);
    #1 check("irq", irq_o, irq_m[IRQ_STOP]);
    wr_reg(ADDR_IRQ_STAT, 32'h7);
    repeat (2) @(posedge clk_i);
    #1 check("irq", irq_o, 1'b0);
    // Clock enable low must freeze the register port
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr_reg(ADDR_MATCH, 32'h0);
    ce_i <= 1'b1;
    rd_chk("frozen", ADDR_MATCH, match_m);
    // Selective mode must ignore the stop fields
    init_mode(MODE_SELECTIVE);
    run_to(2'd1);
    repeat (40) step();
    // Queuing with one filtered subaddress, overflow, then drain
    init_mode(MODE_QUEUING);
    run_to(2'd1);
    wr_reg(ADDR_FILT_SEL, {25'h0, KIND_TX, 5'd5});
    wr_reg(ADDR_FILT_DATA, 32'hffff_fffe);
    filt_m[KIND_TX][5] = 32'hffff_fffe;
    wr_reg(ADDR_FILT_SEL, {25'h0, KIND_MODE, 5'd5});
    rd_chk("filt_sel", ADDR_FILT_SEL, {25'h0, KIND_MODE, 5'd5});
    wr_reg(ADDR_FILT_DATA, 32'hffff_fffe);
    filt_m[KIND_MODE][5] = 32'hffff_fffe;
    repeat (24) send_xfer();
    e = {11'h0, 5'(q_m.size()), 6'h0, cap_m, pat_m};
    rd_chk("status", ADDR_STATUS, e);
    repeat (18) begin
      e = (q_m.size() > 0) ? q_m.pop_front() : EMPTY_WORD;
      rd_chk("queue", ADDR_QUEUE, e);
    end
    rd_chk("irq_stat", ADDR_IRQ_STAT, {29'h0, irq_m});
    wr_reg(ADDR_IRQ_MASK, 32'h4);
    repeat (2) @(posedge clk_i);
    #1 check("irq", irq_o, irq_m[IRQ_QOVF]);
    stop_test();
  end
endmodule : bmct_top_tb
`default_nettype wire

// ### common/bmct_pkg.sv
// Constants and types for the bus monitor capture trigger block.
// Assumes a single 40 MHz clock and a plain strobe register port.
package bmct_pkg;
  // ----------------------------------------
  // Register map (word addresses)
  // ----------------------------------------
  localparam logic [3:0] ADDR_MATCH = 4'h0;
  localparam logic [3:0] ADDR_INDEX = 4'h1;
  localparam logic [3:0] ADDR_CTRL = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
  localparam logic [3:0] ADDR_FILT_SEL = 4'h6;
  localparam logic [3:0] ADDR_FILT_DATA = 4'h7;
  localparam logic [3:0] ADDR_QUEUE = 4'h8;
  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int START_CMP_LSB = 0;
  localparam int START_MSK_LSB = 8;
  localparam int STOP_CMP_LSB = 16;
  localparam int STOP_MSK_LSB = 24;
  localparam int SEQ1_IDX_LSB = 8;
  localparam logic [31:0] INDEX_RW_MASK = 32'h0000ffff;
  localparam logic [7:0] PATTERN_RESET = 8'h00;
  localparam logic [31:0] FILT_RESET = 32'hffffffff;
  localparam logic [31:0] EMPTY_WORD = 32'h80000000;
  localparam int QDEPTH = 16;
  localparam int QAW = 4;
  // Interrupt status bits
  localparam int IRQ_START = 0;
  localparam int IRQ_STOP = 1;
  localparam int IRQ_QOVF = 2;
  // Control register bits
  localparam int CTRL_INIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  // Capture modes
  typedef enum logic [1:0] {
    MODE_STANDARD = 2'b00,
    MODE_SELECTIVE = 2'b01,
    MODE_QUEUING = 2'b10,
    MODE_RECORDING = 2'b11
  } bmct_mode_t;
  // Capture engine states
  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_RUN = 2'b01,
    CAP_DONE = 2'b10
  } bmct_cap_t;
  // Transfer kinds for the record filter
  localparam logic [1:0] KIND_RX = 2'b00;
  localparam logic [1:0] KIND_TX = 2'b01;
  localparam logic [1:0] KIND_MODE = 2'b10;
endpackage : bmct_pkg

// ### common/bmct_trig_if.sv
// Interface from the control block sequencer to the capture engine.
// Assumes both ends share clk_i.
`timescale 1ns/1ps
`default_nettype none
interface bmct_trig_if;
  logic hit;
  logic [7:0] set_mask;
  logic [7:0] clr_mask;
  modport src (output hit, output set_mask, output clr_mask);
  modport dst (input hit, input set_mask, input clr_mask);
endinterface : bmct_trig_if
`default_nettype wire

// ### logic/bmct_seq.sv
// Two parallel trigger sequences evaluating data value conditions.
// Assumes block table entries arrive from the caller's table inputs.
`timescale 1ns/1ps
`default_nettype none
module bmct_seq
  import bmct_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Control
  input wire logic init_i,
  input wire logic [15:0] start_idx_i,
  // Bus word
  input wire logic word_vld_i,
  input wire logic [15:0] word_i,
  input wire logic eom_i,
  // Block table: per sequence current block parameters
  input wire logic [15:0] tbl_mask_i [2],
  input wire logic [15:0] tbl_lo_i [2],
  input wire logic [15:0] tbl_hi_i [2],
  input wire logic [7:0] tbl_set_i [2],
  input wire logic [7:0] tbl_clr_i [2],
  input wire logic [7:0] tbl_next_i [2],
  input wire logic [7:0] tbl_eom_i [2],
  output logic [7:0] cur_idx_o [2],
  // Pattern update
  bmct_trig_if.src trig
);
  // Checks in this module run on clk_i and pause during reset
  default clocking cb_seq @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  // Inclusive range check on a masked word
  function automatic logic in_range(input logic [15:0] w,
      input logic [15:0] m, input logic [15:0] lo, input logic [15:0] hi);
    in_range = ((w & m) >= lo) && ((w & m) <= hi);
  endfunction : in_range

  logic [1:0] hit;
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      hit[s] = word_vld_i &&
        in_range(word_i, tbl_mask_i[s], tbl_lo_i[s], tbl_hi_i[s]);
    end
  end

  // Each sequence walks its own chain
  always_ff @(posedge clk_i) begin
    if (srst_i || init_i) begin
      cur_idx_o[0] <= start_idx_i[7:0];
      cur_idx_o[1] <= start_idx_i[SEQ1_IDX_LSB +: 8];
    end else if (ce_i) begin
      for (int s = 0; s < 2; s++) begin
        if (hit[s]) cur_idx_o[s] <= tbl_next_i[s];
        else if (eom_i) cur_idx_o[s] <= tbl_eom_i[s];
      end
    end
  end

  // Merge both sequences' masks; either may hit in the same cycle
  always_comb begin
    trig.hit = |hit;
    trig.set_mask = (hit[0] ? tbl_set_i[0] : 8'h00) |
      (hit[1] ? tbl_set_i[1] : 8'h00);
    trig.clr_mask = (hit[0] ? tbl_clr_i[0] : 8'h00) |
      (hit[1] ? tbl_clr_i[1] : 8'h00);
  end

  a_range_hit: assert property (word_vld_i &&
    ((word_i & tbl_mask_i[0]) < tbl_lo_i[0]) |-> !hit[0])
    else $error("hit below lower limit");
endmodule : bmct_seq
`default_nettype wire

// ### logic/bmct_top.sv
// Capture trigger, record filter and message queue of the bus monitor.
// Assumes synchronous inputs on clk_i and a one-cycle strobe register port.
`timescale 1ns/1ps
`default_nettype none
module bmct_top
  import bmct_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Bus word feed
  input wire logic word_vld_i,
  input wire logic [15:0] word_i,
  input wire logic eom_i,
  // Block table per sequence
  input wire logic [15:0] tbl_mask_i [2],
  input wire logic [15:0] tbl_lo_i [2],
  input wire logic [15:0] tbl_hi_i [2],
  input wire logic [7:0] tbl_set_i [2],
  input wire logic [7:0] tbl_clr_i [2],
  input wire logic [7:0] tbl_next_i [2],
  input wire logic [7:0] tbl_eom_i [2],
  output logic [7:0] cur_idx_o [2],
  // Transfer to record
  input wire logic xfer_vld_i,
  input wire logic [4:0] xfer_rt_i,
  input wire logic [1:0] xfer_kind_i,
  input wire logic [31:0] xfer_data_i,
  // Status
  output logic capture_o,
  output logic [7:0] pattern_o,
  output logic irq_o
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] capture_start_stop_match_word;
  logic [31:0] sequence_block_index_word;
  bmct_mode_t mode;
  logic init_pulse;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [6:0] filt_sel;
  logic [31:0] filt_en_tx [32];
  logic [31:0] filt_en_rx [32];
  logic [31:0] filt_en_mc [32];
  logic [7:0] pattern;
  bmct_cap_t cap_state;
  logic start_ev, stop_ev, rec_ok;
  logic [7:0] next_pattern;
  logic [7:0] seq_idx [2];

  bmct_trig_if trig_bus();

  // Checks in this module run on clk_i and pause during reset
  default clocking cb_chk @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  bmct_seq u_seq (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .init_i(init_pulse),
    .start_idx_i(sequence_block_index_word[15:0]),
    .word_vld_i(word_vld_i),
    .word_i(word_i),
    .eom_i(eom_i),
    .tbl_mask_i(tbl_mask_i),
    .tbl_lo_i(tbl_lo_i),
    .tbl_hi_i(tbl_hi_i),
    .tbl_set_i(tbl_set_i),
    .tbl_clr_i(tbl_clr_i),
    .tbl_next_i(tbl_next_i),
    .tbl_eom_i(tbl_eom_i),
    .cur_idx_o(seq_idx),
    .trig(trig_bus.src)
  );

  // Masked compare of the pattern with one byte pair of the match word
  function automatic logic pat_match(input logic [7:0] p,
      input logic [7:0] m, input logic [7:0] c);
    pat_match = ((p & m) == c);
  endfunction : pat_match

  // ----------------------------------------
  // Trigger pattern and events
  // ----------------------------------------
  // Set applied after clear so a bit named in both ends up set
  always_comb begin
    next_pattern = (pattern & ~trig_bus.clr_mask)
      | trig_bus.set_mask;
    start_ev = pat_match(pattern,
      capture_start_stop_match_word[START_MSK_LSB +: 8],
      capture_start_stop_match_word[START_CMP_LSB +: 8]);
    stop_ev = (mode == MODE_STANDARD) && pat_match(pattern,
      capture_start_stop_match_word[STOP_MSK_LSB +: 8],
      capture_start_stop_match_word[STOP_CMP_LSB +: 8]);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || init_pulse) begin
      pattern <= PATTERN_RESET;
    end else if (ce_i && trig_bus.hit) begin
      pattern <= next_pattern;
    end
  end

  // Capture engine: a finished run waits for the next initialisation
  always_ff @(posedge clk_i) begin
    if (srst_i || init_pulse) begin
      cap_state <= CAP_IDLE;
    end else if (ce_i) begin
      case (cap_state)
        CAP_IDLE: if (start_ev) cap_state <= CAP_RUN;
        CAP_RUN: if (stop_ev) cap_state <= CAP_DONE;
        CAP_DONE: cap_state <= CAP_DONE;
        default: cap_state <= CAP_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Record filter
  // ----------------------------------------
  always_comb begin
    case (xfer_kind_i)
      KIND_TX: rec_ok = filt_en_tx[xfer_rt_i][xfer_data_i[4:0]];
      KIND_RX: rec_ok = filt_en_rx[xfer_rt_i][xfer_data_i[4:0]];
      KIND_MODE: rec_ok = filt_en_mc[xfer_rt_i][xfer_data_i[4:0]];
      default: rec_ok = 1'b0;
    endcase
  end

  // Filter tables; select word bits 6:5 pick table, 4:0 the terminal
  always_ff @(posedge clk_i) begin
    if (srst_i || init_pulse) begin
      for (int i = 0; i < 32; i++) begin
        filt_en_tx[i] <= FILT_RESET;
        filt_en_rx[i] <= FILT_RESET;
        filt_en_mc[i] <= FILT_RESET;
      end
    end else if (ce_i && wr_i && addr_i == ADDR_FILT_DATA) begin
      case (filt_sel[6:5])
        KIND_TX: filt_en_tx[filt_sel[4:0]] <= wdata_i;
        KIND_RX: filt_en_rx[filt_sel[4:0]] <= wdata_i;
        KIND_MODE: filt_en_mc[filt_sel[4:0]] <= wdata_i;
        default: filt_en_mc[filt_sel[4:0]] <= filt_en_mc[filt_sel[4:0]];
      endcase
    end
  end

  // ----------------------------------------
  // Message queue
  // ----------------------------------------
  logic [31:0] qmem [QDEPTH];
  logic [QAW-1:0] wptr, rptr;
  logic [QAW:0] qcount;
  logic q_push, q_pop, q_ovf;
  // Queue records only filtered transfers while capturing in queuing mode
  assign q_push = ce_i && xfer_vld_i && rec_ok && mode == MODE_QUEUING
    && cap_state == CAP_RUN && qcount != (QAW+1)'(QDEPTH);
  assign q_ovf = ce_i && xfer_vld_i && rec_ok && mode == MODE_QUEUING
    && cap_state == CAP_RUN && !q_push;
  assign q_pop = ce_i && rd_i && addr_i == ADDR_QUEUE && qcount != '0;

  always_ff @(posedge clk_i) begin
    if (q_push) qmem[wptr] <= xfer_data_i;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || init_pulse) begin
      wptr <= '0;
      rptr <= '0;
      qcount <= '0;
    end else begin
      if (q_push) wptr <= wptr + 1'b1;
      if (q_pop) rptr <= rptr + 1'b1;
      qcount <= qcount + (QAW+1)'(q_push) - (QAW+1)'(q_pop);
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  assign init_pulse = ce_i && wr_i && addr_i == ADDR_CTRL
    && wdata_i[CTRL_INIT];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      capture_start_stop_match_word <= '0;
      sequence_block_index_word <= '0;
      mode <= MODE_STANDARD;
      filt_sel <= '0;
      irq_mask <= '0;
    end else if (ce_i && wr_i) begin
      case (addr_i)
        ADDR_MATCH: capture_start_stop_match_word <= wdata_i;
        ADDR_INDEX: sequence_block_index_word <= wdata_i & INDEX_RW_MASK;
        ADDR_CTRL: mode <= bmct_mode_t'(wdata_i[CTRL_MODE_LSB +: 2]);
        ADDR_FILT_SEL: filt_sel <= wdata_i[6:0];
        ADDR_IRQ_MASK: irq_mask <= wdata_i[2:0];
        default: filt_sel <= filt_sel;
      endcase
    end
  end

  // Sticky events: a new event wins over a write-one clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_stat <= '0;
    end else if (ce_i) begin
      irq_stat <= (irq_stat & ~((wr_i && addr_i == ADDR_IRQ_STAT) ?
        wdata_i[2:0] : 3'h0))
        | {q_ovf, cap_state == CAP_RUN && stop_ev,
           cap_state == CAP_IDLE && start_ev};
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= '0;
      if (rd_i) begin
        case (addr_i)
          ADDR_MATCH: rdata_o <= capture_start_stop_match_word;
          ADDR_INDEX: rdata_o <= sequence_block_index_word;
          ADDR_CTRL: rdata_o <= {29'h0, mode, 1'b0};
          ADDR_STATUS: rdata_o <= {11'h0, qcount, 6'h0, cap_state, pattern};
          ADDR_IRQ_STAT: rdata_o <= {29'h0, irq_stat};
          ADDR_IRQ_MASK: rdata_o <= {29'h0, irq_mask};
          ADDR_FILT_SEL: rdata_o <= {25'h0, filt_sel};
          ADDR_QUEUE: rdata_o <= (qcount != '0) ? qmem[rptr]
            : EMPTY_WORD;
          default: rdata_o <= '0;
        endcase
      end
    end
  end

  // Registered status outputs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      capture_o <= 1'b0;
      pattern_o <= PATTERN_RESET;
      irq_o <= 1'b0;
      cur_idx_o[0] <= '0;
      cur_idx_o[1] <= '0;
    end else if (ce_i) begin
      capture_o <= (cap_state == CAP_RUN);
      pattern_o <= pattern;
      irq_o <= |(irq_stat & irq_mask);
      cur_idx_o <= seq_idx;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_hit;
    ce_i && trig_bus.hit && !init_pulse;
  endsequence

  a_pattern_update: assert property (s_hit |=>
    pattern == $past(next_pattern))
    else $error("pattern not updated on hit");
  a_start_run: assert property (ce_i && !init_pulse &&
    cap_state == CAP_IDLE && start_ev |=> cap_state == CAP_RUN)
    else $error("start missed");
  a_stop_ends: assert property (ce_i && !init_pulse &&
    cap_state == CAP_RUN && stop_ev |=> cap_state == CAP_DONE)
    else $error("stop missed");
  a_stop_std_only: assert property (mode != MODE_STANDARD |->
    !stop_ev)
    else $error("stop outside standard mode");
  a_capture_out: assert property (ce_i && cap_state == CAP_RUN |=>
    capture_o)
    else $error("capture output lags");
  a_init_clear: assert property (init_pulse |=>
    pattern == PATTERN_RESET && qcount == '0)
    else $error("init did not clear");
  a_empty_read: assert property (ce_i && rd_i &&
    addr_i == ADDR_QUEUE && qcount == '0 |=> rdata_o == EMPTY_WORD)
    else $error("empty read gave entry");
  a_pop_advance: assert property (q_pop && !init_pulse |=>
    rptr == $past(rptr) + 1'b1)
    else $error("read pointer stuck");
  a_filter_drop: assert property (xfer_vld_i && !rec_ok |->
    !q_push)
    else $error("filtered transfer queued");
endmodule : bmct_top
`default_nettype wire
